// [mts_pkg.sv]
// Package: constants and types for the measurement trigger sequencer.
// Assumes a 20 MHz reference clock.
package mts_pkg;
  typedef enum logic [2:0] {
    MTS_SRC_AUTO,
    MTS_SRC_SINGLE,
    MTS_SRC_EXT,
    MTS_SRC_IMM,
    MTS_SRC_BUS
  } mts_src_e;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SAMP_W = 16;
  localparam int unsigned TRIG_W = 16;
  localparam int unsigned DLY_W = 37;
  localparam logic [SAMP_W-1:0] SAMP_MIN = 16'h0001;
  localparam logic [SAMP_W-1:0] SAMP_MAX = 16'hc350;
  localparam logic [TRIG_W-1:0] TRIG_MIN = 16'h0001;
  localparam logic [TRIG_W-1:0] TRIG_MAX = 16'hc350;
  localparam int unsigned DLY_MAX_S = 3600;
  localparam logic [DLY_W-1:0] DLY_MAX_CYC = 37'(64'(DLY_MAX_S) * 64'(CLK_HZ));
  // Auto delay figures in microseconds, then in reference clock cycles
  localparam int unsigned AUTO_SHORT_US = 1000;
  localparam int unsigned AUTO_LONG_US = 1500;
  localparam logic [DLY_W-1:0] AUTO_SHORT_CYC = 37'(AUTO_SHORT_US * (CLK_HZ / 1000000));
  localparam logic [DLY_W-1:0] AUTO_LONG_CYC = 37'(AUTO_LONG_US * (CLK_HZ / 1000000));
endpackage

// [mts_cfg_if.sv]
// Interface: settings handed from the settings store to the sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
interface mts_cfg_if;
  logic [2:0] src;
  logic [15:0] samp_cnt;
  logic [15:0] trig_cnt;
  logic trig_inf;
  logic dly_auto;
  logic [36:0] dly_cyc;
  modport store (output src, samp_cnt, trig_cnt, trig_inf, dly_auto, dly_cyc);
  modport seq (input src, samp_cnt, trig_cnt, trig_inf, dly_auto, dly_cyc);
endinterface

// [mts_settings.sv]
// Settings store: trigger source, counts and delay.
// Assumes write strobes are single-cycle pulses; device clear is not an input here.
`timescale 1ns/1ps
module mts_settings (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic remote_i,
  input wire logic set_default_i,
  input wire logic preset_i,
  input wire logic src_wr_i,
  input wire logic [2:0] src_i,
  input wire logic samp_wr_i,
  input wire logic [15:0] samp_i,
  input wire logic trig_wr_i,
  input wire logic [15:0] trig_i,
  input wire logic trig_inf_i,
  input wire logic dly_wr_i,
  input wire logic dly_auto_i,
  input wire logic [36:0] dly_i,
  mts_cfg_if.store cfg
);
  logic [2:0] src_ff;
  logic [15:0] samp_ff;
  logic [15:0] trig_ff;
  logic inf_ff;
  logic auto_ff;
  logic [36:0] dly_ff;

  function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] hi);
    clip16 = (v == 16'h0000) ? 16'h0001 : ((v > hi) ? hi : v);
  endfunction

  // ==========================================
  // Source
  // default source on reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || set_default_i) begin
      src_ff <= remote_i ? 3'(mts_pkg::MTS_SRC_IMM) : 3'(mts_pkg::MTS_SRC_AUTO);
      if (set_default_i) begin
        src_ff <= 3'(mts_pkg::MTS_SRC_IMM);
      end
    end else if (src_wr_i) begin
      src_ff <= src_i;
    end
  end

  // ==========================================
  // Counts
  // sample count range and default
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || set_default_i) begin
      samp_ff <= mts_pkg::SAMP_MIN;
    end else if (samp_wr_i) begin
      samp_ff <= clip16(samp_i, mts_pkg::SAMP_MAX);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || set_default_i || preset_i) begin
      trig_ff <= mts_pkg::TRIG_MIN;
      inf_ff <= 1'b0;
    end else if (trig_wr_i) begin
      trig_ff <= clip16(trig_i, mts_pkg::TRIG_MAX);
      inf_ff <= trig_inf_i;
    end
  end

  // ==========================================
  // Delay
  // delay range, auto default
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || set_default_i) begin
      auto_ff <= 1'b1;
      dly_ff <= '0;
    end else if (dly_wr_i) begin
      auto_ff <= dly_auto_i;
      dly_ff <= (dly_i > mts_pkg::DLY_MAX_CYC) ? mts_pkg::DLY_MAX_CYC : dly_i;
    end
  end

  assign cfg.src = src_ff;
  assign cfg.samp_cnt = samp_ff;
  assign cfg.trig_cnt = trig_ff;
  assign cfg.trig_inf = inf_ff;
  assign cfg.dly_auto = auto_ff;
  assign cfg.dly_cyc = dly_ff;
endmodule

// [mts_delay.sv]
// Delay timer: counts down a loaded cycle figure, pulses done at zero.
// Assumes load is a single-cycle pulse; abort wins over load.
`timescale 1ns/1ps
module mts_delay #(
  parameter int unsigned W = 37
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic abort_i,
  input wire logic load_i,
  input wire logic [W-1:0] cyc_i,
  output logic done_o
);
  logic [W-1:0] cnt_ff;
  logic run_ff;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || abort_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_ff <= cyc_i;
      run_ff <= 1'b1;
      done_o <= 1'b0;
    end else if (run_ff) begin
      done_o <= (cnt_ff == '0);
      run_ff <= (cnt_ff != '0);
      cnt_ff <= (cnt_ff == '0) ? cnt_ff : cnt_ff - W'(1);
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// [mts_seq.sv]
// Trigger sequencer top: arming, trigger source selection, delay and
// reading handshake toward the measurement engine.
// Assumes all inputs are synchronous to ref_clk_i and commands are pulses.
`timescale 1ns/1ps
module mts_seq (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic remote_i,
  input wire logic set_default_i,
  input wire logic preset_i,
  input wire logic src_wr_i,
  input wire logic [2:0] src_i,
  input wire logic samp_wr_i,
  input wire logic [15:0] samp_i,
  input wire logic trig_wr_i,
  input wire logic [15:0] trig_i,
  input wire logic trig_inf_i,
  input wire logic dly_wr_i,
  input wire logic dly_auto_i,
  input wire logic [36:0] dly_i,
  input wire logic nplc_ge1_i,
  input wire logic arm_i,
  input wire logic dev_clear_i,
  input wire logic single_key_i,
  input wire logic ext_trig_n_i,
  input wire logic bus_trg_i,
  input wire logic get_msg_i,
  input wire logic rdg_done_i,
  output logic rdg_start_o,
  output logic waiting_o,
  output logic busy_o,
  output logic trig_ignored_o,
  output logic ext_pending_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DELAY,
    ST_READ
  } mts_state_e;

  mts_cfg_if cfg();

  mts_state_e state_ff;
  mts_state_e nxt_state;
  logic [15:0] samp_left_ff;
  logic [15:0] trig_done_ff;
  logic ext_prev_ff;
  logic ext_buf_ff;
  logic dly_load;
  logic dly_done;
  logic [36:0] dly_cyc;
  logic trig_now;
  logic ext_fall;
  logic key_ok;
  logic burst_end;
  logic last_trig;
  logic [15:0] eff_trig;

  mts_settings u_settings (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .remote_i(remote_i),
    .set_default_i(set_default_i),
    .preset_i(preset_i),
    .src_wr_i(src_wr_i),
    .src_i(src_i),
    .samp_wr_i(samp_wr_i),
    .samp_i(samp_i),
    .trig_wr_i(trig_wr_i),
    .trig_i(trig_i),
    .trig_inf_i(trig_inf_i),
    .dly_wr_i(dly_wr_i),
    .dly_auto_i(dly_auto_i),
    .dly_i(dly_i),
    .cfg(cfg.store)
  );

  mts_delay #(.W(37)) u_delay (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .abort_i(dev_clear_i),
    .load_i(dly_load),
    .cyc_i(dly_cyc),
    .done_o(dly_done)
  );

  // ==========================================
  // Trigger qualification
  // low-true edge detect
  assign ext_fall = ext_prev_ff & ~ext_trig_n_i;
  assign key_ok = single_key_i & ~remote_i;

  always_comb begin
    trig_now = 1'b0;
    unique case (mts_pkg::mts_src_e'(cfg.src))
      mts_pkg::MTS_SRC_AUTO: trig_now = 1'b1;
      mts_pkg::MTS_SRC_SINGLE: trig_now = key_ok | ext_fall | ext_buf_ff;
      mts_pkg::MTS_SRC_EXT: trig_now = ext_fall | ext_buf_ff;
      mts_pkg::MTS_SRC_IMM: trig_now = 1'b1;
      mts_pkg::MTS_SRC_BUS: trig_now = bus_trg_i | get_msg_i;
      default: trig_now = 1'b0;
    endcase
  end

  assign dly_cyc = cfg.dly_auto ?
    (nplc_ge1_i ? mts_pkg::AUTO_LONG_CYC : mts_pkg::AUTO_SHORT_CYC) : cfg.dly_cyc;

  assign eff_trig = remote_i ? cfg.trig_cnt : 16'h0001;
  assign last_trig = ~(remote_i & cfg.trig_inf) && (trig_done_ff + 16'h0001 >= eff_trig);
  assign burst_end = (state_ff == ST_READ) && rdg_done_i && (samp_left_ff <= 16'h0001);

  // ==========================================
  // State machine
  always_comb begin
    nxt_state = state_ff;
    dly_load = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (arm_i || (!remote_i && cfg.src != 3'(mts_pkg::MTS_SRC_BUS))) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_now) begin
          nxt_state = ST_DELAY;
          dly_load = 1'b1;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        if (rdg_done_i) begin
          if (samp_left_ff > 16'h0001) begin
            nxt_state = ST_DELAY;
            dly_load = 1'b1;
          end else if (last_trig && remote_i) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dev_clear_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================
  // Counters
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dev_clear_i) begin
      samp_left_ff <= 16'h0000;
    end else if (state_ff == ST_WAIT && trig_now) begin
      samp_left_ff <= cfg.samp_cnt;
    end else if (state_ff == ST_READ && rdg_done_i) begin
      samp_left_ff <= samp_left_ff - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    // Local use restarts the count, so a return to remote begins afresh
    if (srst_i || dev_clear_i || state_ff == ST_IDLE || !remote_i) begin
      trig_done_ff <= 16'h0000;
    end else if (burst_end) begin
      trig_done_ff <= trig_done_ff + 16'h0001;
    end
  end

  // ==========================================
  // External trigger buffer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ext_prev_ff <= 1'b1;
    end else begin
      ext_prev_ff <= ext_trig_n_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dev_clear_i) begin
      ext_buf_ff <= 1'b0;
    end else if (ext_fall && (state_ff == ST_DELAY || state_ff == ST_READ)) begin
      ext_buf_ff <= 1'b1;
    end else if (state_ff == ST_WAIT || state_ff == ST_IDLE) begin
      // Stale trigger must not fire a later arm
      ext_buf_ff <= 1'b0;
    end
  end

  // ==========================================
  // Outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dev_clear_i) begin
      rdg_start_o <= 1'b0;
      waiting_o <= 1'b0;
      busy_o <= 1'b0;
      ext_pending_o <= 1'b0;
    end else begin
      rdg_start_o <= (state_ff == ST_DELAY) && dly_done;
      waiting_o <= (nxt_state == ST_WAIT);
      busy_o <= (nxt_state == ST_DELAY) || (nxt_state == ST_READ);
      ext_pending_o <= ext_buf_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      trig_ignored_o <= 1'b0;
    end else begin
      trig_ignored_o <= (bus_trg_i | get_msg_i) && (state_ff != ST_WAIT);
    end
  end

  // ==========================================
  // Checks
  a_clear_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    dev_clear_i |=> (state_ff == ST_IDLE) && !busy_o)
    else $error("device clear did not return to idle");

  a_bus_ignored: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (bus_trg_i && state_ff == ST_IDLE) |=> trig_ignored_o)
    else $error("unarmed bus trigger not flagged");

  a_bus_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_WAIT && cfg.src == 3'(mts_pkg::MTS_SRC_BUS) && !bus_trg_i && !get_msg_i)
    |=> state_ff == ST_WAIT)
    else $error("bus source left wait without trigger");

  a_imm_fire: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_WAIT && cfg.src == 3'(mts_pkg::MTS_SRC_IMM)) |=> state_ff == ST_DELAY)
    else $error("immediate source did not fire");

  a_key_remote: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_WAIT && remote_i && cfg.src == 3'(mts_pkg::MTS_SRC_SINGLE)
     && !ext_fall && !ext_buf_ff) |=> state_ff == ST_WAIT)
    else $error("one-shot key acted in remote");

  a_ext_buffer: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (ext_fall && state_ff == ST_READ) |=> ext_buf_ff)
    else $error("external trigger not buffered");

  a_start_after: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    rdg_start_o |-> $past(state_ff) == ST_DELAY)
    else $error("reading started without delay");

  a_samp_range: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (cfg.samp_cnt >= mts_pkg::SAMP_MIN) && (cfg.samp_cnt <= mts_pkg::SAMP_MAX))
    else $error("sample count out of range");

  a_default_src: assert property (@(posedge ref_clk_i)
    set_default_i && !srst_i |=> cfg.src == 3'(mts_pkg::MTS_SRC_IMM))
    else $error("configure did not force immediate");

  // Steps of a taken trigger
  sequence s_trig_taken;
    state_ff == ST_WAIT && trig_now;
  endsequence

  sequence s_in_delay;
    state_ff == ST_DELAY && busy_o;
  endsequence

  // Held external trigger at burst end, front panel in control
  sequence s_ext_held;
    ext_buf_ff && burst_end && !remote_i && cfg.src == 3'(mts_pkg::MTS_SRC_EXT);
  endsequence

  sequence s_wait_then_delay;
    state_ff == ST_WAIT ##1 state_ff == ST_DELAY;
  endsequence

  a_trig_delay: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    s_trig_taken |=> s_in_delay)
    else $error("taken trigger did not start the delay");

  a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_IDLE && remote_i && !arm_i) |=> state_ff == ST_IDLE)
    else $error("left idle without arming");

  a_arm_wait: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_IDLE && arm_i) |=> (state_ff == ST_WAIT) && waiting_o)
    else $error("arm did not enter wait");

  a_ext_issue: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    s_ext_held |=> s_wait_then_delay)
    else $error("held external trigger not issued");

  a_burst_repeat: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (state_ff == ST_READ && rdg_done_i && samp_left_ff > 16'h0001) |=> s_in_delay)
    else $error("no delay before next reading of burst");

  a_count_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (remote_i && !cfg.trig_inf && last_trig && burst_end) |=> state_ff == ST_IDLE)
    else $error("did not idle after last trigger");

  a_inf_runs: assert property (@(posedge ref_clk_i) disable iff (srst_i || dev_clear_i)
    (remote_i && cfg.trig_inf && burst_end) |=> state_ff != ST_IDLE)
    else $error("infinite count stopped without clear");
endmodule

// [mts_far_model.sv]
// Far-side model: measurement engine and external trigger source.
// Assumes one clock; requests are one-cycle pulses sampled on the rising edge.
`timescale 1ns/1ps
module mts_far_model (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic abort_i,
  input wire logic rdg_start_i,
  input wire logic [7:0] lat_i,
  input wire logic ext_req_i,
  output logic rdg_done_o,
  output logic ext_trig_n_o
);
  logic [7:0] eng_ff;
  logic [1:0] ext_ff;
  // ==========================================
  // Engine: done lat_i cycles after each start
  always_ff @(posedge ref_clk_i) begin
    rdg_done_o <= 1'b0;
    if (srst_i || abort_i) begin
      eng_ff <= 8'h00;
    end else if (rdg_start_i) begin
      eng_ff <= lat_i;
    end else if (eng_ff != 8'h00) begin
      eng_ff <= eng_ff - 8'h01;
      rdg_done_o <= (eng_ff == 8'h01);
    end
  end
  // ==========================================
  // low-true trigger pulse
  // Pin is pulled up, so it idles high between pulses
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) ext_ff <= 2'h0;
    else if (ext_req_i) ext_ff <= 2'h3;
    else if (ext_ff != 2'h0) ext_ff <= ext_ff - 2'h1;
  end
  assign ext_trig_n_o = (ext_ff == 2'h0);
endmodule

// [testbench.sv]
// Testbench: trigger sequencer against the engine and trigger-source model.
// Assumes a 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
  localparam int ARM = 0, CLR = 1, KEY = 2, BUS = 3, GET = 4, DEF = 5, PRE = 6, EXT = 7;
  logic ref_clk = 1'b0, srst = 1'b1, remote = 1'b1, set_def = 1'b0, preset = 1'b0;
  logic src_wr = 1'b0, samp_wr = 1'b0, trig_wr = 1'b0, trig_inf = 1'b0, dly_wr = 1'b0;
  logic dly_auto = 1'b0, nplc = 1'b0, arm = 1'b0, clr = 1'b0, key = 1'b0, bus_trg = 1'b0;
  logic get_msg = 1'b0, ext_req = 1'b0;
  logic [2:0] src = 3'h0;
  logic [15:0] samp = 16'h0001, trig = 16'h0001;
  logic [36:0] dly = 37'h0;
  logic [7:0] lat = 8'h04;
  logic rdg_done, ext_n, rdg_start, waiting, busy, ign, ext_pend;
  int error_cnt = 0, cmp_count = 0, cyc = 0, nst = 0, nign = 0;
  int base, ign0, first_t, last_t, min_gap, arm_t, n;
  // ==========================================
  // Clock, instances and monitors
  always #25 ref_clk = ~ref_clk;
  mts_seq i_mts_seq (
    .ref_clk_i(ref_clk), .srst_i(srst), .remote_i(remote), .set_default_i(set_def),
    .preset_i(preset), .src_wr_i(src_wr), .src_i(src), .samp_wr_i(samp_wr), .samp_i(samp),
    .trig_wr_i(trig_wr), .trig_i(trig), .trig_inf_i(trig_inf), .dly_wr_i(dly_wr),
    .dly_auto_i(dly_auto), .dly_i(dly), .nplc_ge1_i(nplc), .arm_i(arm), .dev_clear_i(clr),
    .single_key_i(key), .ext_trig_n_i(ext_n), .bus_trg_i(bus_trg), .get_msg_i(get_msg),
    .rdg_done_i(rdg_done), .rdg_start_o(rdg_start), .waiting_o(waiting), .busy_o(busy),
    .trig_ignored_o(ign), .ext_pending_o(ext_pend));
  mts_far_model i_mts_far_model (
    .ref_clk_i(ref_clk), .srst_i(srst), .abort_i(clr), .rdg_start_i(rdg_start),
    .lat_i(lat), .ext_req_i(ext_req), .rdg_done_o(rdg_done), .ext_trig_n_o(ext_n));
  always @(posedge ref_clk) begin
    cyc++;
    if (ign === 1'b1) nign++;
    if (rdg_start === 1'b1) begin
      nst++;
      if (nst - base == 1) first_t = cyc;
      else if (cyc - last_t < min_gap) min_gap = cyc - last_t;
      last_t = cyc;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pls(input int k);
    @(negedge ref_clk);
    arm_t = cyc + 1;
    case (k)
      ARM: arm = 1'b1;
      CLR: clr = 1'b1;
      KEY: key = 1'b1;
      BUS: bus_trg = 1'b1;
      GET: get_msg = 1'b1;
      DEF: set_def = 1'b1;
      PRE: preset = 1'b1;
      default: ext_req = 1'b1;
    endcase
    @(negedge ref_clk);
    {arm, clr, key, bus_trg, get_msg, set_def, preset, ext_req} = 8'h00;
  endtask
  task automatic cfg(input logic [2:0] s, input logic [15:0] ns, input logic [15:0] nt,
                     input logic inf, input logic [36:0] d);
    @(negedge ref_clk);
    {src, samp, trig, trig_inf, dly, dly_auto} = {s, ns, nt, inf, d, 1'b0};
    {src_wr, samp_wr, trig_wr, dly_wr} = 4'hf;
    @(negedge ref_clk);
    {src_wr, samp_wr, trig_wr, dly_wr} = 4'h0;
  endtask
  task automatic new_test();
    base = nst;
    ign0 = nign;
    min_gap = 1000000;
  endtask
  task automatic wait_st(input int k, input int lim);
    for (int i = 0; i < lim && nst - base < k; i++) @(negedge ref_clk);
  endtask
  task automatic idle_chk(input int k);
    repeat (40) @(negedge ref_clk);
    chk(nst - base, k);
    chk(busy, 1'b0);
    chk(waiting, 1'b0);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_src();
    new_test();
    repeat (50) @(negedge ref_clk);
    chk(nst - base, 0);
    pls(ARM);
    wait_st(1, 21000);
    idle_chk(1);
    n = int'(mts_pkg::AUTO_SHORT_CYC);
    chk(first_t - arm_t >= n + 2 && first_t - arm_t <= n + 4, 1'b1);
    $display("test reset_src done");
  endtask
  task automatic t_burst();
    cfg(mts_pkg::MTS_SRC_IMM, 16'h0003, 16'h0002, 1'b0, 37'h5);
    new_test();
    pls(ARM);
    wait_st(6, 500);
    idle_chk(6);
    chk(min_gap >= 8, 1'b1);
    $display("test burst done");
  endtask
  task automatic t_bus();
    cfg(mts_pkg::MTS_SRC_BUS, 16'h0001, 16'h0002, 1'b0, 37'h2);
    new_test();
    pls(BUS);
    repeat (3) @(negedge ref_clk);
    chk(nign - ign0, 1);
    chk(nst - base, 0);
    pls(ARM);
    repeat (3) @(negedge ref_clk);
    chk(waiting, 1'b1);
    pls(BUS);
    wait_st(1, 100);
    chk(nst - base, 1);
    repeat (20) @(negedge ref_clk);
    pls(GET);
    wait_st(2, 100);
    idle_chk(2);
    chk(nign - ign0, 1);
    $display("test bus done");
  endtask
  task automatic t_clear();
    cfg(mts_pkg::MTS_SRC_IMM, 16'h0002, 16'h0001, 1'b1, 37'h5);
    new_test();
    pls(ARM);
    wait_st(5, 500);
    chk(nst - base, 5);
    pls(CLR);
    repeat (3) @(negedge ref_clk);
    chk(busy, 1'b0);
    chk(waiting, 1'b0);
    n = nst;
    repeat (60) @(negedge ref_clk);
    chk(nst - n, 0);
    new_test();
    pls(ARM);
    wait_st(4, 500);
    chk(nst - base, 4);
    chk(min_gap >= 8, 1'b1);
    pls(CLR);
    repeat (5) @(negedge ref_clk);
    $display("test clear done");
  endtask
  task automatic t_ext();
    lat = 8'h1e;
    cfg(mts_pkg::MTS_SRC_EXT, 16'h0001, 16'h0003, 1'b0, 37'h5);
    // Go local only once the source is set, else the old one self-arms
    remote = 1'b0;
    repeat (10) @(negedge ref_clk);
    new_test();
    pls(EXT);
    repeat (12) @(negedge ref_clk);
    pls(EXT);
    repeat (4) @(negedge ref_clk);
    chk(ext_pend, 1'b1);
    wait_st(2, 200);
    repeat (60) @(negedge ref_clk);
    chk(nst - base, 2);
    chk(nign - ign0, 0);
    lat = 8'h04;
    $display("test ext done");
  endtask
  task automatic t_single();
    cfg(mts_pkg::MTS_SRC_SINGLE, 16'h0002, 16'h0001, 1'b0, 37'h5);
    repeat (10) @(negedge ref_clk);
    new_test();
    pls(KEY);
    repeat (80) @(negedge ref_clk);
    chk(nst - base, 2);
    pls(EXT);
    repeat (80) @(negedge ref_clk);
    chk(nst - base, 4);
    remote = 1'b1;
    repeat (3) @(negedge ref_clk);
    pls(KEY);
    repeat (60) @(negedge ref_clk);
    chk(nst - base, 4);
    $display("test single done");
  endtask
  task automatic t_default();
    // Back to idle first, so the new source cannot fire from wait
    pls(CLR);
    cfg(mts_pkg::MTS_SRC_IMM, 16'h0001, 16'h0003, 1'b0, 37'h5);
    pls(PRE);
    new_test();
    pls(ARM);
    wait_st(1, 100);
    idle_chk(1);
    cfg(mts_pkg::MTS_SRC_BUS, 16'h0003, 16'h0002, 1'b0, 37'h5);
    nplc = 1'b1;
    pls(DEF);
    new_test();
    pls(ARM);
    wait_st(1, 31000);
    idle_chk(1);
    n = int'(mts_pkg::AUTO_LONG_CYC);
    chk(first_t - arm_t >= n + 2 && first_t - arm_t <= n + 4, 1'b1);
    $display("test default done");
  endtask
  task automatic t_auto();
    @(negedge ref_clk);
    {srst, remote} = 2'b10;
    repeat (3) @(negedge ref_clk);
    // Zero delay lands before the first load
    {srst, dly_wr, dly_auto, dly} = {1'b0, 1'b1, 1'b0, 37'h0};
    @(negedge ref_clk);
    dly_wr = 1'b0;
    new_test();
    wait_st(4, 60);
    chk(nst - base, 4);
    chk(min_gap <= 10, 1'b1);
    chk(busy | waiting, 1'b1);
    $display("test auto done");
  endtask
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    t_reset_src();
    t_burst();
    t_bus();
    t_clear();
    t_ext();
    t_single();
    t_default();
    t_auto();
    stop_test();
  end
  // Tests need about 51000 cycles; leave headroom
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
endmodule
